// file: hdl/eis_pkg.sv
package eis_pkg;

   // ***************************************************************
   // Host region zero map
   // ***************************************************************
   localparam int EIS_ADDR_W = 6;
   localparam logic [5:0] EIS_CSR_OFFSET = 6'h38;
   localparam int EIS_DATA_W = 32;

   // ***************************************************************
   // Control and status word fields
   // ***************************************************************
   localparam int EIS_POL_BIT = 6;
   localparam int EIS_EN_BIT = 12;
   localparam int EIS_PEND_BIT = 17;
   localparam int EIS_MISS_BIT = 23;

   localparam logic EIS_POL_RST = 1'h0;
   localparam logic EIS_EN_RST = 1'h0;
   localparam logic EIS_PEND_RST = 1'h0;
   localparam logic EIS_MISS_RST = 1'h0;

   // ***************************************************************
   // Port groups
   // ***************************************************************
   localparam int EIS_GROUPS = 4;
   localparam int EIS_GROUP_W = 24;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic sel;
      logic wr;
      logic rd;
      logic [EIS_ADDR_W-1:0] addr;
      logic [EIS_DATA_W-1:0] wdata;
   } eis_host_req_s;

   typedef struct packed {
      logic [EIS_GROUPS-1:0] latch_en;
      logic [EIS_GROUPS-1:0] fall_sel;
   } eis_grp_mode_s;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic gate_s1;
      logic gate_s2;
      logic pol;
      logic en;
      logic pend;
      logic miss;
      logic rd_valid;
      logic [EIS_DATA_W-1:0] rdata;
      logic latch_stb;
      logic [EIS_GROUPS-1:0] latch_mask;
      logic [EIS_GROUPS-1:0][EIS_GROUP_W-1:0] latched;
   } eis_state_s;

endpackage

// file: hdl/eis_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - Control and status word is a 32-bit register at region-zero offset 0x38.
// - Bit 6 picks rising edge when 0, falling edge when 1.
// - Polarity and enable bits are readable and changed only by host writes.
// - Bit 12 turns group-3 top inputs into request and gate; else no service.
// - Gate held low lets request edges be detected.
// - Gate high makes all request edges ignored.
// - Request edges for input latching are detected per the port-group latch polarity settings.
// - A detected edge captures inputs of every group set to latch.
// - An accepted edge sets the pending flag, bit 17.
// - An accepted edge raises the host interrupt request.
// - While pending, further edges do nothing except count as missed.
// - First edge arriving while pending sets the missed flag, bit 23.
// - Only one missed flag; later missed edges leave no further record.
// - Writing 1 to bit 17 or 23 clears it; host acks both, then sets bit 6.
// - Polarity, enable, pending and missed bits reset to 0.
// - Group mode bits choose no latching, or latching on rising or falling edge.
// - Mixed group polarities make every latching group detect both edges.
module eis_unit
   import eis_pkg::*;
#(
   parameter int GROUPS = EIS_GROUPS,
   parameter int GROUP_W = EIS_GROUP_W
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Host I/O region zero
   input wire eis_host_req_s host_req,
   output logic [EIS_DATA_W-1:0] host_rdata,
   output logic host_rvalid,
   // Host interrupt
   output logic host_irq,
   // Port group 3 upper port C lines
   input wire logic port_c_line_six,
   input wire logic port_c_line_seven,
   output logic port_c_upper_general,
   // Port group modes and inputs
   input wire eis_grp_mode_s grp_mode,
   input wire logic [GROUPS-1:0][GROUP_W-1:0] grp_in,
   // Latched inputs
   output logic latch_stb,
   output logic [GROUPS-1:0] latch_mask,
   output logic [GROUPS-1:0][GROUP_W-1:0] grp_latched
);

   // ***************************************************************
   // Reset release
   // ***************************************************************
   logic rst_meta;
   logic rst_n_sync;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta <= 1'b0;
         rst_n_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n_sync <= rst_meta;
      end
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic edge_hit(input logic fall, input logic rise_e, input logic fall_e);
      edge_hit = fall ? fall_e : rise_e;
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************
   eis_state_s st_reg;
   eis_state_s st_next;

   logic rise_evt;
   logic fall_evt;
   logic armed;
   logic csr_edge;
   logic mixed;
   logic [GROUPS-1:0] grp_hit;
   logic grp_edge;
   logic any_edge;
   logic accept_evt;
   logic latch_evt;
   logic csr_wr;
   logic csr_rd;

   always_comb
   begin
      st_next = st_reg;
      // Synchronisers and edge history
      st_next.req_s1 = port_c_line_six;
      st_next.req_s2 = st_reg.req_s1;
      st_next.req_s3 = st_reg.req_s2;
      st_next.gate_s1 = port_c_line_seven;
      st_next.gate_s2 = st_reg.gate_s1;
      rise_evt = st_reg.req_s2 && !st_reg.req_s3;
      fall_evt = !st_reg.req_s2 && st_reg.req_s3;
      // Enable and gate qualify all edges
      armed = st_reg.en && !st_reg.gate_s2;
      csr_edge = edge_hit(st_reg.pol, rise_evt, fall_evt);
      // Group latch edge selection
      mixed = |(grp_mode.latch_en & grp_mode.fall_sel)
         && |(grp_mode.latch_en & ~grp_mode.fall_sel);
      for (int g = 0; g < GROUPS; g++)
      begin
         grp_hit[g] = grp_mode.latch_en[g]
            && (mixed ? (rise_evt || fall_evt)
                      : edge_hit(grp_mode.fall_sel[g], rise_evt, fall_evt));
      end
      grp_edge = |grp_hit;
      any_edge = armed && (csr_edge || grp_edge);
      accept_evt = armed && csr_edge && !st_reg.pend;
      latch_evt = armed && grp_edge && !st_reg.pend;
      // Host access decode
      csr_wr = host_req.sel && host_req.wr && host_req.addr == EIS_CSR_OFFSET;
      csr_rd = host_req.sel && host_req.rd;
      // Control bits change only by host writes
      if (csr_wr)
      begin
         st_next.pol = host_req.wdata[EIS_POL_BIT];
         st_next.en = host_req.wdata[EIS_EN_BIT];
      end
      // Pending: set wins over write-one clear
      if (accept_evt)
      begin
         st_next.pend = 1'b1;
      end
      else if (csr_wr && host_req.wdata[EIS_PEND_BIT])
      begin
         st_next.pend = 1'b0;
      end
      // Missed: single sticky record, set wins over clear
      if (st_reg.pend && any_edge)
      begin
         st_next.miss = 1'b1;
      end
      else if (csr_wr && host_req.wdata[EIS_MISS_BIT])
      begin
         st_next.miss = 1'b0;
      end
      // Input capture
      st_next.latch_stb = latch_evt;
      if (latch_evt)
      begin
         st_next.latch_mask = grp_hit;
         for (int g = 0; g < GROUPS; g++)
         begin
            if (grp_hit[g])
            begin
               st_next.latched[g] = grp_in[g];
            end
         end
      end
      // Read data, unmapped offsets read zero
      st_next.rd_valid = csr_rd;
      if (csr_rd)
      begin
         st_next.rdata = '0;
         if (host_req.addr == EIS_CSR_OFFSET)
         begin
            st_next.rdata[EIS_POL_BIT] = st_reg.pol;
            st_next.rdata[EIS_EN_BIT] = st_reg.en;
            st_next.rdata[EIS_PEND_BIT] = st_reg.pend;
            st_next.rdata[EIS_MISS_BIT] = st_reg.miss;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_sync)
   begin
      if (!rst_n_sync)
      begin
         st_reg <= '0;
         st_reg.pol <= EIS_POL_RST;
         st_reg.en <= EIS_EN_RST;
         st_reg.pend <= EIS_PEND_RST;
         st_reg.miss <= EIS_MISS_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign host_rdata = st_reg.rdata;
   assign host_rvalid = st_reg.rd_valid;
   assign host_irq = st_reg.pend;
   assign port_c_upper_general = !st_reg.en;
   assign latch_stb = st_reg.latch_stb;
   assign latch_mask = st_reg.latch_mask;
   assign grp_latched = st_reg.latched;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_accept_sets_pend;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (st_reg.en && !st_reg.gate_s2 && !st_reg.pend && !st_reg.pol
         && st_reg.req_s2 && !st_reg.req_s3) |=> st_reg.pend;
   endproperty
   a_accept_sets_pend: assert property (p_accept_sets_pend)
      else $error("rising edge accepted but pending not set");

   property p_irq_follows;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      accept_evt |=> host_irq ##1 (host_irq || $past(csr_wr));
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("host interrupt not raised after accepted edge");

   property p_wrong_edge;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (!st_reg.pend && !st_reg.pol && !(st_reg.req_s2 && !st_reg.req_s3)) |=> !st_reg.pend;
   endproperty
   a_wrong_edge: assert property (p_wrong_edge)
      else $error("pending set without a rising edge at polarity 0");

   property p_gate_blocks;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (st_reg.gate_s2 && !st_reg.pend && !st_reg.miss)
         |=> (!st_reg.pend && !st_reg.miss && !latch_stb);
   endproperty
   a_gate_blocks: assert property (p_gate_blocks)
      else $error("edge acted on while gate high");

   property p_disabled;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (!st_reg.en && !st_reg.pend) |=> (!st_reg.pend && !latch_stb);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("interrupt activity while disabled");

   property p_first_miss;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (st_reg.pend && any_edge) |=> (st_reg.miss && !latch_stb);
   endproperty
   a_first_miss: assert property (p_first_miss)
      else $error("edge during pending not recorded as missed");

   property p_w1c_pend;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (csr_wr && host_req.wdata[EIS_PEND_BIT] && !accept_evt) |=> !st_reg.pend;
   endproperty
   a_w1c_pend: assert property (p_w1c_pend)
      else $error("pending flag not cleared by write of one");

   property p_ctrl_stable;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      !csr_wr |=> ($stable(st_reg.pol) && $stable(st_reg.en));
   endproperty
   a_ctrl_stable: assert property (p_ctrl_stable)
      else $error("control bit changed without host write");

   property p_latch_data;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (latch_evt && grp_hit[0]) |=> (grp_latched[0] == $past(grp_in[0]) && latch_stb);
   endproperty
   a_latch_data: assert property (p_latch_data)
      else $error("group 0 inputs not captured on edge");

   property p_csr_read;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (csr_rd && host_req.addr == EIS_CSR_OFFSET)
         |=> (host_rvalid && host_rdata[EIS_PEND_BIT] == $past(st_reg.pend));
   endproperty
   a_csr_read: assert property (p_csr_read)
      else $error("status word read returned wrong pending bit");

   property p_rd_unmapped;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (csr_rd && host_req.addr != EIS_CSR_OFFSET) |=> (host_rvalid && host_rdata == '0);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped offset read returned nonzero data");

   property p_pend_no_latch;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      st_reg.pend |=> !latch_stb;
   endproperty
   a_pend_no_latch: assert property (p_pend_no_latch)
      else $error("inputs captured while pending");

   property p_miss_sticky;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (st_reg.miss && !(csr_wr && host_req.wdata[EIS_MISS_BIT])) |=> st_reg.miss;
   endproperty
   a_miss_sticky: assert property (p_miss_sticky)
      else $error("missed flag dropped without a clearing write");

   property p_w1c_miss;
      @(posedge clk_sys) disable iff (!rst_n_sync)
      (csr_wr && host_req.wdata[EIS_MISS_BIT] && !(st_reg.pend && any_edge)) |=> !st_reg.miss;
   endproperty
   a_w1c_miss: assert property (p_w1c_miss)
      else $error("missed flag not cleared by write of one");

endmodule // eis_unit

// file: tb/eis_ext_src.sv
`timescale 1ns/1ps
// *******************
// User circuit model
// *******************
module eis_ext_src
(
   // Clock
   input wire logic clk_sys,
   // Bench control
   input wire logic go,
   input wire logic gate_hi,
   // User circuit pins
   output logic req,
   output logic gate_n,
   output logic busy
);
   logic [3:0] cnt_reg = 4'h0;
   always_ff @(posedge clk_sys)
   begin
      if (go && cnt_reg == 4'h0)
         cnt_reg <= 4'hC;
      else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
   end
   // Six cycles high, six low
   assign req = (cnt_reg > 4'h6);
   assign gate_n = gate_hi;
   assign busy = (cnt_reg != 4'h0);
endmodule // eis_ext_src

// file: tb/test_external_interrupt_status_unit.sv
`timescale 1ns/1ps
module test_external_interrupt_status_unit;
   import eis_pkg::*;
   // *******************
   // Signals
   // *******************
   logic clk_sys = 1'h0;
   logic rstn = 1'h0;
   eis_host_req_s host_req = '0;
   eis_grp_mode_s grp_mode = '0;
   logic [EIS_GROUPS-1:0][EIS_GROUP_W-1:0] grp_in =
      {24'hC3C3C3, 24'h5A5A5A, 24'h0F0F0F, 24'h123456};
   logic [EIS_DATA_W-1:0] host_rdata;
   logic host_rvalid, host_irq, port_c_line_six, port_c_line_seven, port_c_upper_general;
   logic latch_stb;
   logic [EIS_GROUPS-1:0] latch_mask;
   logic [EIS_GROUPS-1:0][EIS_GROUP_W-1:0] grp_latched;
   logic go = 1'h0;
   logic gate_hi = 1'h1;
   logic busy;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_stb = 0;
   int cycles = 0;

   always #10 clk_sys = ~clk_sys;

   eis_unit #(.GROUPS(EIS_GROUPS), .GROUP_W(EIS_GROUP_W)) dut
   (
      .clk_sys(clk_sys), .rstn(rstn), .host_req(host_req), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .host_irq(host_irq), .port_c_line_six(port_c_line_six),
      .port_c_line_seven(port_c_line_seven), .port_c_upper_general(port_c_upper_general),
      .grp_mode(grp_mode), .grp_in(grp_in), .latch_stb(latch_stb), .latch_mask(latch_mask),
      .grp_latched(grp_latched)
   );

   eis_ext_src src
   (
      .clk_sys(clk_sys), .go(go), .gate_hi(gate_hi), .req(port_c_line_six),
      .gate_n(port_c_line_seven), .busy(busy)
   );

   // *******************
   // Tasks
   // *******************
   task automatic end_of_test();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(negedge clk_sys);
      host_req = '{sel: 1'h1, wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(negedge clk_sys);
      host_req = '0;
   endtask

   task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
      @(negedge clk_sys);
      host_req = '{sel: 1'h1, wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
      @(negedge clk_sys);
      host_req = '0;
      chk({31'h0, host_rvalid}, 32'h1);
      chk(host_rdata, exp);
   endtask

   // Checks the interrupt five cycles after the rising edge
   task automatic pulse(input logic irq_mid);
      int i;
      @(negedge clk_sys);
      go = 1'h1;
      @(negedge clk_sys);
      go = 1'h0;
      repeat (5) @(negedge clk_sys);
      chk({31'h0, host_irq}, {31'h0, irq_mid});
      for (i = 0; i < 40 && busy !== 1'h0; i++)
         @(negedge clk_sys);
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (latch_stb === 1'h1)
         n_stb++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end

   // *******************
   // Tests
   // *******************
   initial
   begin
      repeat (20) @(negedge clk_sys);
      rstn = 1'h1;
      repeat (3) @(negedge clk_sys);
      rdc(6'h38, 32'h0);
      chk({31'h0, port_c_upper_general}, 32'h1);
      wr(6'h34, 32'hFFFFFFFF);
      rdc(6'h34, 32'h0);
      rdc(6'h38, 32'h0);
      gate_hi = 1'h0;
      grp_mode = '{latch_en: 4'h5, fall_sel: 4'h0};
      pulse(1'h0);
      rdc(6'h38, 32'h0);
      wr(6'h38, 32'hFFFFFFBF);
      rdc(6'h38, 32'h00001000);
      chk({31'h0, port_c_upper_general}, 32'h0);
      gate_hi = 1'h1;
      repeat (4) @(negedge clk_sys);
      pulse(1'h0);
      gate_hi = 1'h0;
      repeat (4) @(negedge clk_sys);
      pulse(1'h1);
      rdc(6'h38, 32'h00021000);
      chk(n_stb, 1);
      chk({28'h0, latch_mask}, 32'h5);
      chk({8'h0, grp_latched[0]}, {8'h0, grp_in[0]});
      chk({8'h0, grp_latched[2]}, {8'h0, grp_in[2]});
      chk({8'h0, grp_latched[1]}, 32'h0);
      pulse(1'h1);
      rdc(6'h38, 32'h00821000);
      pulse(1'h1);
      rdc(6'h38, 32'h00821000);
      chk(n_stb, 1);
      wr(6'h38, 32'h00821000);
      rdc(6'h38, 32'h00001000);
      chk({31'h0, host_irq}, 32'h0);
      wr(6'h38, 32'h00001040);
      grp_mode = '{latch_en: 4'hF, fall_sel: 4'hF};
      pulse(1'h0);
      rdc(6'h38, 32'h00021040);
      chk({28'h0, latch_mask}, 32'hF);
      chk(n_stb, 2);
      wr(6'h38, 32'h00821000);
      rdc(6'h38, 32'h00001000);
      grp_mode = '{latch_en: 4'hF, fall_sel: 4'h3};
      pulse(1'h1);
      rdc(6'h38, 32'h00821000);
      chk(n_stb, 3);
      rstn = 1'h0;
      repeat (2) @(negedge clk_sys);
      rstn = 1'h1;
      repeat (3) @(negedge clk_sys);
      rdc(6'h38, 32'h0);
      chk({31'h0, host_irq}, 32'h0);
      end_of_test();
   end
endmodule // test_external_interrupt_status_unit
